// *** bench/cfg_link_properties.sv ***
`timescale 1ns/1ps
module cfg_link_chk
    import cfg_parse_pkg::*;
#(
    parameter logic [31:0] APPLY_DELAY = APPLY_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic char_valid,
    input wire logic msg_end,
    input wire logic [5:0] poll_addr,
    input wire logic power_restored,
    input wire logic device_error,
    input wire logic [3:0][31:0] var_in,
    input wire link_cfg_t link_cfg_r,
    input wire alarm_cfg_t alarm_cfg_r,
    input wire link_cfg_t pend_link_r,
    input wire logic settling_r,
    input wire logic msg_accepted_r,
    input wire logic [3:0][31:0] var_out_r
);
    logic [31:0] since_r, since_nxt;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // counts edges since the last power return
    always_comb begin
        since_nxt = since_r;
        if (power_restored)
            since_nxt = 32'h1;
        else if (since_r != 32'h0)
            since_nxt = since_r + 32'h1;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            since_r <= 32'h0;
        else
            since_r <= since_nxt;
    end
    sequence s_nan_err;
        device_error && alarm_cfg_r.mode == ALM_NAN;
    endsequence
    a_frame_shape_fixed: assert property (link_cfg_r.data_bits == FRAME_DATA_BITS
        && link_cfg_r.start_bits == FRAME_START_BITS && pend_link_r.data_bits == FRAME_DATA_BITS)
        else $error("shape changed");
    a_reset_factory: assert property ($fell(rst) |-> link_cfg_r == LINK_FACTORY)
        else $error("not factory");
    a_accept_needs_poll: assert property (msg_accepted_r
        |-> $past(msg_end && !char_valid && poll_addr == CFG_POLL_ADDR)) else $error("bad accept");
    a_pend_only_accept: assert property ($changed(pend_link_r) |-> msg_accepted_r)
        else $error("pend changed");
    a_settle_start: assert property (power_restored |=> settling_r)
        else $error("no settle");
    a_settle_length: assert property ($fell(settling_r) |-> since_r == APPLY_DELAY + 32'h1)
        else $error("settle time wrong");
    a_apply_moment: assert property (($changed(link_cfg_r) || $changed(alarm_cfg_r))
        |-> $past(settling_r) && !settling_r) else $error("apply timing");
    a_alarm_nan: assert property (s_nan_err |=> var_out_r == {4{NAN_WORD}})
        else $error("nan wrong");
    a_alarm_user: assert property (device_error && alarm_cfg_r.mode == ALM_USER
        |=> var_out_r == {4{$past(alarm_cfg_r.user)}}) else $error("user wrong");
    a_alarm_hold: assert property (device_error && alarm_cfg_r.mode == ALM_HOLD
        |=> $stable(var_out_r)) else $error("hold wrong");
    a_vars_pass: assert property (!device_error |=> var_out_r == $past(var_in))
        else $error("pass wrong");
endmodule // cfg_link_chk
bind serial_link_config_string_parser cfg_link_chk #(.APPLY_DELAY(APPLY_DELAY)) chk (
    .clk(clk), .rst(rst), .char_valid(char_valid), .msg_end(msg_end), .poll_addr(poll_addr),
    .power_restored(power_restored), .device_error(device_error), .var_in(var_in),
    .link_cfg_r(link_cfg_r), .alarm_cfg_r(alarm_cfg_r), .pend_link_r(pend_link_r),
    .settling_r(settling_r), .msg_accepted_r(msg_accepted_r), .var_out_r(var_out_r));

// *** bench/cfg_tool_model.sv ***
`timescale 1ns/1ps
module cfg_tool_model
    import cfg_parse_pkg::*;
(
    input wire logic clk,
    input wire logic accepted,
    output logic char_valid,
    output logic [7:0] char_data,
    output logic msg_end
);
    // idle lines at time zero
    initial begin
        char_valid = 1'b0;
        char_data = 8'h00;
        msg_end = 1'b0;
    end
    // sends one string and reports the accept pulse
    task automatic send(input string s, input bit pfx, output bit acc);
        logic [7:0] q[$];
        if (pfx)
            q = '{CH_PFX0, CH_PFX1, CH_PFX2};
        foreach (s[i]) q.push_back(s[i]);
        foreach (q[i]) begin
            @(negedge clk);
            char_valid = 1'b1;
            char_data = q[i];
        end
        @(negedge clk);
        char_valid = 1'b0;
        char_data = ~char_data; // released data flips
        msg_end = 1'b1;
        @(negedge clk);
        msg_end = 1'b0;
        acc = accepted;
    endtask
endmodule // cfg_tool_model

// *** bench/serial_link_config_string_parser_tb.sv ***
`timescale 1ns/1ps
module serial_link_config_string_parser_tb;
    import cfg_parse_pkg::*;
    localparam logic [31:0] SIM_DELAY = 32'd20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic char_valid, msg_end;
    logic [7:0] char_data;
    logic [5:0] poll_addr = 6'h01;
    logic power_restored = 1'b0;
    logic device_error = 1'b0;
    logic [3:0][31:0] var_in = '0;
    link_cfg_t link_cfg_r, pend_link_r;
    alarm_cfg_t alarm_cfg_r, pend_alarm_r;
    logic change_pending_r, settling_r, msg_accepted_r;
    logic [3:0][31:0] var_out_r;
    int num_errors = 0;
    int n_checks = 0;
    always #10 clk = ~clk;
    serial_link_config_string_parser #(.APPLY_DELAY(SIM_DELAY)) uut (.clk(clk), .rst(rst),
        .char_valid(char_valid), .char_data(char_data), .msg_end(msg_end),
        .poll_addr(poll_addr), .power_restored(power_restored), .device_error(device_error),
        .var_in(var_in), .link_cfg_r(link_cfg_r), .alarm_cfg_r(alarm_cfg_r),
        .pend_link_r(pend_link_r), .pend_alarm_r(pend_alarm_r),
        .change_pending_r(change_pending_r), .settling_r(settling_r),
        .msg_accepted_r(msg_accepted_r), .var_out_r(var_out_r));
    cfg_tool_model tool (.clk(clk), .accepted(msg_accepted_r), .char_valid(char_valid),
        .char_data(char_data), .msg_end(msg_end));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmd(input string s, input bit pfx, input bit exp_acc);
        bit a;
        tool.send(s, pfx, a);
        chk("acc", 32'(exp_acc), 32'(a));
    endtask
    task automatic chk_pend(input logic [7:0] ad, input baud_t b, input parity_t p, input logic s2);
        chk("addr", 32'(ad), 32'(pend_link_r.addr));
        chk("baud", 32'(b), 32'(pend_link_r.baud));
        chk("parity", 32'(p), 32'(pend_link_r.parity));
        chk("stop2", 32'(s2), 32'(pend_link_r.stop2));
    endtask
    task automatic apply();
        chk("pend", 32'h1, 32'(change_pending_r));
        @(negedge clk);
        power_restored = 1'b1;
        @(negedge clk);
        power_restored = 1'b0;
        chk("settling", 32'h1, 32'(settling_r));
        repeat (SIM_DELAY) @(negedge clk);
        chk("settled", 32'h0, 32'(settling_r));
        chk("pend", 32'h0, 32'(change_pending_r));
    endtask
    task automatic err_out(input logic [31:0] exp);
        device_error = 1'b1;
        @(negedge clk);
        foreach (var_out_r[i]) chk("var", exp, var_out_r[i]);
        device_error = 1'b0;
    endtask
    task automatic t_link();
        int r[6] = '{1200, 2400, 4800, 9600, 19200, 38400};
        chk("active", 32'(LINK_FACTORY), 32'(link_cfg_r));
        chk_pend(FACT_ADDR, BR_9600, PAR_EVEN, 1'b0);
        cmd(" A044 B4800 PO S2", 1'b1, 1'b1);
        chk_pend(8'h2c, BR_4800, PAR_ODD, 1'b1);
        cmd(" B19200", 1'b1, 1'b1);
        chk_pend(8'h2c, BR_19200, PAR_ODD, 1'b1);
        cmd(" A248 B1234 PX S3", 1'b1, 1'b1);
        chk_pend(8'h2c, BR_19200, PAR_ODD, 1'b1);
        cmd(" A247 PN S1 A0", 1'b1, 1'b1);
        chk_pend(8'hf7, BR_19200, PAR_NONE, 1'b0);
        foreach (r[i]) begin
            cmd($sformatf(" B%0d", r[i]), 1'b1, 1'b1);
            chk("baud", i, 32'(pend_link_r.baud));
        end
        cmd(" PE S2", 1'b1, 1'b1);
        chk_pend(8'hf7, BR_38400, PAR_EVEN, 1'b1);
        cmd("", 1'b1, 1'b1);
        chk_pend(ALT_ADDR, BR_38400, PAR_NONE, 1'b0);
        cmd(" A5", 1'b0, 1'b0);
        @(negedge clk);
        poll_addr = 6'h02;
        cmd(" A5", 1'b1, 1'b0);
        poll_addr = 6'h01;
        chk_pend(ALT_ADDR, BR_38400, PAR_NONE, 1'b0);
        chk("early", 32'(LINK_FACTORY), 32'(link_cfg_r));
        apply();
        chk("applied", 32'(pend_link_r), 32'(link_cfg_r));
        chk("addr", 32'(ALT_ADDR), 32'(link_cfg_r.addr));
        $display("test link done");
    endtask
    task automatic t_alarm();
        cmd({" E", "U-0.1"}, 1'b1, 1'b1);
        chk("user", 32'hffffff9c, pend_alarm_r.user);
        apply();
        var_in = {4{32'h12345678}};
        err_out(32'hffffff9c);
        cmd({" E", "F"}, 1'b1, 1'b1);
        apply();
        var_in = {4{32'h0badf00d}};
        err_out(32'h12345678);
        cmd(" EN", 1'b1, 1'b1);
        apply();
        err_out(NAN_WORD);
        @(negedge clk);
        foreach (var_out_r[i]) chk("pass", 32'h0badf00d, var_out_r[i]);
        $display("test alarm done");
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // reset, then the tests
    initial begin
        repeat (5) @(negedge clk);
        rst = 1'b0;
        t_link();
        t_alarm();
        conclude();
    end
    // watchdog against a hang
    initial begin
        #100_000;
        num_errors++;
        conclude();
    end
endmodule // serial_link_config_string_parser_tb

// *** core/cfg_parse_pkg.sv ***
// Operation
// - With nothing ordered, the link runs at 9600 baud, even parity, one stop bit, station 1.
// - A frame always has one start bit and eight data bits, and no string can change that.
// - A string is acted on only when the three prefix characters lead it.
// - The address field is a decimal station number from 1 to 247, leading zeros allowed.
// - The baud field is accepted only as 1200, 2400, 4800, 9600, 19200 or 38400.
// - The parity field is one letter choosing odd, even or no parity for the frame.
// - The stop field is the digit 1 or 2 and sets one or two stop bits.
// - Any field may be left out, and an omitted field keeps its current value.
// - A string of the prefix alone sets no parity, one stop bit and station 246, nothing else.
// - Strings are processed only while the polling address equals 1, which the tool sets.
// - New link and alarm settings take effect 60 seconds after power returns.
// - The alarm selector picks not-a-number (default), hold last value, or a signed user value.
// - On a device error the chosen alarm output replaces all four process variable words.
package cfg_parse_pkg;

    // character codes seen in the configuration text
    localparam logic [7:0] CH_PFX0 = 8'h48;
    localparam logic [7:0] CH_PFX1 = 8'h4d;
    localparam logic [7:0] CH_PFX2 = 8'h43;
    localparam logic [7:0] CH_SPACE = 8'h20;
    localparam logic [7:0] CH_ADDR = 8'h41;
    localparam logic [7:0] CH_BAUD = 8'h42;
    localparam logic [7:0] CH_PAR = 8'h50;
    localparam logic [7:0] CH_STOP = 8'h53;
    localparam logic [7:0] CH_ALM = 8'h45;
    localparam logic [7:0] CH_ODD = 8'h4f;
    localparam logic [7:0] CH_EVEN = 8'h45;
    localparam logic [7:0] CH_NONE = 8'h4e;
    localparam logic [7:0] CH_HOLD = 8'h46;
    localparam logic [7:0] CH_USER = 8'h55;
    localparam logic [7:0] CH_MINUS = 8'h2d;
    localparam logic [7:0] CH_DOT = 8'h2e;
    localparam logic [7:0] CH_ZERO = 8'h30;
    localparam logic [7:0] CH_ONE = 8'h31;
    localparam logic [7:0] CH_TWO = 8'h32;
    localparam logic [7:0] CH_NINE = 8'h39;

    // decimal accumulator width and value limits
    localparam int ACC_W = 20;
    localparam logic [ACC_W-1:0] ADDR_MIN = 20'h00001;
    localparam logic [ACC_W-1:0] ADDR_MAX = 20'h000f7;
    localparam logic [ACC_W-1:0] BAUD_1200 = 20'h004b0;
    localparam logic [ACC_W-1:0] BAUD_2400 = 20'h00960;
    localparam logic [ACC_W-1:0] BAUD_4800 = 20'h012c0;
    localparam logic [ACC_W-1:0] BAUD_9600 = 20'h02580;
    localparam logic [ACC_W-1:0] BAUD_19200 = 20'h04b00;
    localparam logic [ACC_W-1:0] BAUD_38400 = 20'h09600;

    // station addresses and polling address
    localparam logic [7:0] FACT_ADDR = 8'h01;
    localparam logic [7:0] ALT_ADDR = 8'hf6;
    localparam logic [5:0] CFG_POLL_ADDR = 6'h01;

    // fixed frame shape
    localparam logic [3:0] FRAME_DATA_BITS = 4'h8;
    localparam logic [1:0] FRAME_START_BITS = 2'h1;

    // user alarm value is held in thousandths
    localparam logic [1:0] USER_FRAC_MAX = 2'h3;
    localparam logic [31:0] NAN_WORD = 32'h7fc00000;

    // settle time after power returns
    localparam longint unsigned APPLY_SECONDS = 64'd60;
    localparam longint unsigned CLK_HZ = 64'd50_000_000;
    localparam logic [31:0] APPLY_CYCLES = 32'(APPLY_SECONDS * CLK_HZ);

    typedef enum logic [2:0] {BR_1200, BR_2400, BR_4800, BR_9600, BR_19200, BR_38400} baud_t;
    typedef enum logic [1:0] {PAR_NONE, PAR_ODD, PAR_EVEN} parity_t;
    typedef enum logic [1:0] {ALM_NAN, ALM_HOLD, ALM_USER} alarm_mode_t;

    typedef struct packed {
        logic [7:0] addr;
        baud_t baud;
        parity_t parity;
        logic stop2;
        logic [3:0] data_bits;
        logic [1:0] start_bits;
    } link_cfg_t;

    typedef struct packed {
        alarm_mode_t mode;
        logic signed [31:0] user;
    } alarm_cfg_t;

    localparam link_cfg_t LINK_FACTORY = '{addr: FACT_ADDR, baud: BR_9600, parity: PAR_EVEN,
        stop2: 1'b0, data_bits: FRAME_DATA_BITS, start_bits: FRAME_START_BITS};
    localparam alarm_cfg_t ALARM_FACTORY = '{mode: ALM_NAN, user: 32'sh00000000};

    // map a decimal rate to its code, bit 3 set when the rate is legal
    function automatic logic [3:0] baud_lookup(input logic [ACC_W-1:0] v);
        unique case (v)
            BAUD_1200: baud_lookup = {1'b1, BR_1200};
            BAUD_2400: baud_lookup = {1'b1, BR_2400};
            BAUD_4800: baud_lookup = {1'b1, BR_4800};
            BAUD_9600: baud_lookup = {1'b1, BR_9600};
            BAUD_19200: baud_lookup = {1'b1, BR_19200};
            BAUD_38400: baud_lookup = {1'b1, BR_38400};
            default: baud_lookup = 4'h0;
        endcase
    endfunction

    function automatic logic is_digit(input logic [7:0] c);
        is_digit = (c >= CH_ZERO) && (c <= CH_NINE);
    endfunction

endpackage

// *** core/dec_accum.sv ***
`timescale 1ns/1ps
// decimal digit accumulator, saturating with a sticky overflow flag
module dec_accum #(
    parameter int W = 20
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clr,
    input wire logic digit_valid,
    input wire logic [3:0] digit,
    output logic [W-1:0] value_r,
    output logic ovf_r
);
    logic [W-1:0] value_nxt;
    logic ovf_nxt;
    logic [W+4:0] wide;

    // value times ten plus the new digit
    always_comb begin
        wide = {5'h00, value_r} * (W+5)'(10) + (W+5)'(digit);
        value_nxt = value_r;
        ovf_nxt = ovf_r;
        if (clr) begin
            value_nxt = '0;
            ovf_nxt = 1'b0;
        end else if (digit_valid) begin
            if (wide[W+4:W] != 5'h00) begin
                value_nxt = '1;
                ovf_nxt = 1'b1;
            end else begin
                value_nxt = wide[W-1:0];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            value_r <= '0;
            ovf_r <= 1'b0;
        end else begin
            value_r <= value_nxt;
            ovf_r <= ovf_nxt;
        end
    end
endmodule // dec_accum

// *** core/serial_link_config_string_parser.sv ***
`timescale 1ns/1ps
// parses the message-field text, keeps pending settings and applies them after power returns
module serial_link_config_string_parser
    import cfg_parse_pkg::*;
#(
    parameter logic [31:0] APPLY_DELAY = APPLY_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic char_valid,
    input wire logic [7:0] char_data,
    input wire logic msg_end,
    input wire logic [5:0] poll_addr,
    input wire logic power_restored,
    input wire logic device_error,
    input wire logic [3:0][31:0] var_in,
    output link_cfg_t link_cfg_r,
    output alarm_cfg_t alarm_cfg_r,
    output link_cfg_t pend_link_r,
    output alarm_cfg_t pend_alarm_r,
    output logic change_pending_r,
    output logic settling_r,
    output logic msg_accepted_r,
    output logic [3:0][31:0] var_out_r
);
    typedef enum logic [2:0] {S_PFX, S_GAP, S_VAL, S_SKIP, S_REJ} pstate_t;
    typedef enum logic [2:0] {K_ADDR, K_BAUD, K_PAR, K_STOP, K_ALM} key_t;

    pstate_t st_r, st_nxt;
    key_t key_r, key_nxt;
    logic [1:0] pfx_idx_r, pfx_idx_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic bad_r, bad_nxt;
    logic [7:0] sel_r, sel_nxt;
    logic neg_r, neg_nxt;
    logic dot_r, dot_nxt;
    logic [1:0] frac_r, frac_nxt;
    logic dig_r, dig_nxt;
    logic seen_r, seen_nxt;
    link_cfg_t stg_link_r, stg_link_nxt, pend_link_nxt, fld_link, fin_link;
    alarm_cfg_t stg_alarm_r, stg_alarm_nxt, pend_alarm_nxt, fld_alarm, fin_alarm;
    logic msg_accepted_nxt;
    logic acc_clr, acc_dv;
    logic [3:0] acc_digit;
    logic [ACC_W-1:0] acc_val;
    logic acc_ovf;
    logic [3:0] baud_hit;
    logic [31:0] mag;
    logic [7:0] pfx_char;
    logic [ACC_W+9:0] scaled;

    dec_accum #(.W(ACC_W)) u_acc (
        .clk(clk),
        .rst(rst),
        .clr(acc_clr),
        .digit_valid(acc_dv),
        .digit(acc_digit),
        .value_r(acc_val),
        .ovf_r(acc_ovf)
    );

    // settings as they would stand if the current field ended now
    always_comb begin
        fld_link = stg_link_r;
        fld_alarm = stg_alarm_r;
        baud_hit = baud_lookup(acc_val);
        unique case (frac_r)
            2'h0: scaled = {10'h000, acc_val} * 30'd1000;
            2'h1: scaled = {10'h000, acc_val} * 30'd100;
            2'h2: scaled = {10'h000, acc_val} * 30'd10;
            default: scaled = {10'h000, acc_val};
        endcase
        mag = 32'(scaled);
        unique case (key_r)
            K_ADDR: begin
                if (!bad_r && cnt_r != 4'h0 && !acc_ovf && acc_val >= ADDR_MIN
                        && acc_val <= ADDR_MAX) begin
                    fld_link.addr = acc_val[7:0];
                end
            end
            K_BAUD: begin
                if (!bad_r && cnt_r != 4'h0 && !acc_ovf && baud_hit[3]) begin
                    fld_link.baud = baud_t'(baud_hit[2:0]);
                end
            end
            K_PAR: begin
                if (!bad_r && cnt_r == 4'h1) begin
                    if (sel_r == CH_ODD) begin
                        fld_link.parity = PAR_ODD;
                    end else if (sel_r == CH_EVEN) begin
                        fld_link.parity = PAR_EVEN;
                    end else if (sel_r == CH_NONE) begin
                        fld_link.parity = PAR_NONE;
                    end
                end
            end
            K_STOP: begin
                if (!bad_r && cnt_r == 4'h1 && (sel_r == CH_ONE || sel_r == CH_TWO)) begin
                    fld_link.stop2 = (sel_r == CH_TWO);
                end
            end
            K_ALM: begin
                if (!bad_r && cnt_r == 4'h1 && sel_r == CH_NONE) begin
                    fld_alarm.mode = ALM_NAN;
                end else if (!bad_r && cnt_r == 4'h1 && sel_r == CH_HOLD) begin
                    fld_alarm.mode = ALM_HOLD;
                end else if (!bad_r && sel_r == CH_USER && dig_r
                        && !acc_ovf) begin
                    fld_alarm.mode = ALM_USER;
                    fld_alarm.user = neg_r ? -$signed(mag) : $signed(mag);
                end
            end
        endcase
    end

    // character-by-character parser and pending-setting update
    always_comb begin
        st_nxt = st_r;
        key_nxt = key_r;
        pfx_idx_nxt = pfx_idx_r;
        cnt_nxt = cnt_r;
        bad_nxt = bad_r;
        sel_nxt = sel_r;
        neg_nxt = neg_r;
        dot_nxt = dot_r;
        frac_nxt = frac_r;
        dig_nxt = dig_r;
        seen_nxt = seen_r;
        stg_link_nxt = stg_link_r;
        stg_alarm_nxt = stg_alarm_r;
        pend_link_nxt = pend_link_r;
        pend_alarm_nxt = pend_alarm_r;
        msg_accepted_nxt = 1'b0;
        acc_clr = 1'b0;
        acc_dv = 1'b0;
        acc_digit = char_data[3:0];
        fin_link = (st_r == S_VAL) ? fld_link : stg_link_r;
        fin_alarm = (st_r == S_VAL) ? fld_alarm : stg_alarm_r;
        unique case (pfx_idx_r)
            2'h0: pfx_char = CH_PFX0;
            2'h1: pfx_char = CH_PFX1;
            default: pfx_char = CH_PFX2;
        endcase
        if (char_valid) begin
            unique case (st_r)
                S_PFX: begin
                    if (char_data == pfx_char) begin
                        pfx_idx_nxt = pfx_idx_r + 2'h1;
                        if (pfx_idx_r == 2'h2) begin
                            st_nxt = S_GAP;
                        end
                    end else begin
                        st_nxt = S_REJ;
                    end
                end
                S_GAP: begin
                    if (char_data != CH_SPACE) begin
                        seen_nxt = 1'b1;
                        cnt_nxt = 4'h0;
                        bad_nxt = 1'b0;
                        neg_nxt = 1'b0;
                        dot_nxt = 1'b0;
                        frac_nxt = 2'h0;
                        dig_nxt = 1'b0;
                        acc_clr = 1'b1;
                        st_nxt = S_VAL;
                        unique case (char_data)
                            CH_ADDR: key_nxt = K_ADDR;
                            CH_BAUD: key_nxt = K_BAUD;
                            CH_PAR: key_nxt = K_PAR;
                            CH_STOP: key_nxt = K_STOP;
                            CH_ALM: key_nxt = K_ALM;
                            default: st_nxt = S_SKIP;
                        endcase
                    end
                end
                S_VAL: begin
                    if (char_data == CH_SPACE) begin
                        stg_link_nxt = fld_link;
                        stg_alarm_nxt = fld_alarm;
                        st_nxt = S_GAP;
                    end else begin
                        if (cnt_r != 4'hf) begin
                            cnt_nxt = cnt_r + 4'h1;
                        end
                        if (cnt_r == 4'h0) begin
                            sel_nxt = char_data;
                        end
                        unique case (key_r)
                            K_ADDR, K_BAUD: begin
                                if (is_digit(char_data)) begin
                                    acc_dv = 1'b1;
                                end else begin
                                    bad_nxt = 1'b1;
                                end
                            end
                            K_PAR, K_STOP: begin
                                if (cnt_r != 4'h0) begin
                                    bad_nxt = 1'b1;
                                end
                            end
                            K_ALM: begin
                                if (cnt_r == 4'h0) begin
                                    bad_nxt = 1'b0;
                                end else if (sel_r != CH_USER) begin
                                    bad_nxt = 1'b1;
                                end else if (char_data == CH_MINUS && cnt_r == 4'h1) begin
                                    neg_nxt = 1'b1;
                                end else if (char_data == CH_DOT && !dot_r) begin
                                    dot_nxt = 1'b1;
                                end else if (is_digit(char_data)) begin
                                    dig_nxt = 1'b1;
                                    if (!dot_r || frac_r != USER_FRAC_MAX) begin
                                        acc_dv = 1'b1;
                                        frac_nxt = dot_r ? frac_r + 2'h1 : frac_r;
                                    end
                                end else begin
                                    bad_nxt = 1'b1;
                                end
                            end
                        endcase
                    end
                end
                S_SKIP: begin
                    if (char_data == CH_SPACE) begin
                        st_nxt = S_GAP;
                    end
                end
                S_REJ: begin
                    st_nxt = S_REJ;
                end
            endcase
        end else if (msg_end) begin
            st_nxt = S_PFX;
            pfx_idx_nxt = 2'h0;
            seen_nxt = 1'b0;
            if (poll_addr == CFG_POLL_ADDR && st_r != S_PFX && st_r != S_REJ) begin
                if (!seen_r) begin
                    fin_link.parity = PAR_NONE;
                    fin_link.stop2 = 1'b0;
                    fin_link.addr = ALT_ADDR;
                end
                pend_link_nxt = fin_link;
                pend_alarm_nxt = fin_alarm;
                stg_link_nxt = fin_link;
                stg_alarm_nxt = fin_alarm;
                msg_accepted_nxt = 1'b1;
            end else begin
                stg_link_nxt = pend_link_r;
                stg_alarm_nxt = pend_alarm_r;
            end
        end
        pend_link_nxt.data_bits = FRAME_DATA_BITS;
        pend_link_nxt.start_bits = FRAME_START_BITS;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= S_PFX;
            key_r <= K_ADDR;
            pfx_idx_r <= 2'h0;
            cnt_r <= 4'h0;
            bad_r <= 1'b0;
            sel_r <= 8'h00;
            neg_r <= 1'b0;
            dot_r <= 1'b0;
            frac_r <= 2'h0;
            dig_r <= 1'b0;
            seen_r <= 1'b0;
            stg_link_r <= LINK_FACTORY;
            stg_alarm_r <= ALARM_FACTORY;
            pend_link_r <= LINK_FACTORY;
            pend_alarm_r <= ALARM_FACTORY;
            msg_accepted_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            key_r <= key_nxt;
            pfx_idx_r <= pfx_idx_nxt;
            cnt_r <= cnt_nxt;
            bad_r <= bad_nxt;
            sel_r <= sel_nxt;
            neg_r <= neg_nxt;
            dot_r <= dot_nxt;
            frac_r <= frac_nxt;
            dig_r <= dig_nxt;
            seen_r <= seen_nxt;
            stg_link_r <= stg_link_nxt;
            stg_alarm_r <= stg_alarm_nxt;
            pend_link_r <= pend_link_nxt;
            pend_alarm_r <= pend_alarm_nxt;
            msg_accepted_r <= msg_accepted_nxt;
        end
    end

    logic [31:0] dly_r, dly_nxt;
    link_cfg_t link_cfg_nxt;
    alarm_cfg_t alarm_cfg_nxt;
    logic settling_nxt, change_pending_nxt;

    // settle timer: pending settings become active once power has been back long enough
    always_comb begin
        dly_nxt = dly_r;
        link_cfg_nxt = link_cfg_r;
        alarm_cfg_nxt = alarm_cfg_r;
        if (power_restored) begin
            dly_nxt = APPLY_DELAY;
        end else if (dly_r != 32'h0) begin
            dly_nxt = dly_r - 32'h1;
            if (dly_r == 32'h1) begin
                link_cfg_nxt = pend_link_r;
                alarm_cfg_nxt = pend_alarm_r;
            end
        end
        settling_nxt = (dly_nxt != 32'h0);
        change_pending_nxt = (pend_link_nxt != link_cfg_nxt) || (pend_alarm_nxt != alarm_cfg_nxt);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dly_r <= 32'h0;
            link_cfg_r <= LINK_FACTORY;
            alarm_cfg_r <= ALARM_FACTORY;
            settling_r <= 1'b0;
            change_pending_r <= 1'b0;
        end else begin
            dly_r <= dly_nxt;
            link_cfg_r <= link_cfg_nxt;
            alarm_cfg_r <= alarm_cfg_nxt;
            settling_r <= settling_nxt;
            change_pending_r <= change_pending_nxt;
        end
    end

    logic [3:0][31:0] var_out_nxt;

    // process variable words, replaced by the alarm output while the device is in error
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (!device_error) begin
                var_out_nxt[i] = var_in[i];
            end else begin
                unique case (alarm_cfg_r.mode)
                    ALM_HOLD: var_out_nxt[i] = var_out_r[i];
                    ALM_USER: var_out_nxt[i] = alarm_cfg_r.user;
                    default: var_out_nxt[i] = NAN_WORD;
                endcase
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            var_out_r <= '0;
        end else begin
            var_out_r <= var_out_nxt;
        end
    end
endmodule // serial_link_config_string_parser
